// ==== prp_profile.sv ====
// The APB interface to the registers and the placing of the registers were left to the implementer.
module prp_profile (
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic pulse_out, // one-cycle pulse to driver
  output logic dir_out, // direction, high for negative move
  output logic busy // move in progress
);
  prp_pulse_if pg ();
  logic [prp_pkg::DIV_W-1:0] speed_unit_divider;
  logic [prp_pkg::RDP_W-1:0] ramp_down_point;
  logic [prp_pkg::SPAN_W-1:0] s_curve_accel_span;
  logic [prp_pkg::SPAN_W-1:0] s_curve_decel_span;
  logic ramp_point_method;
  logic ramp_shape_select;
  logic [prp_pkg::SPD_W-1:0] low_speed_setting;
  logic [prp_pkg::SPD_W-1:0] high_speed_setting;
  logic [prp_pkg::SPD_W-1:0] accel_rate_setting;
  logic [prp_pkg::SPD_W-1:0] decel_rate_setting;
  logic [prp_pkg::MOVE_W-1:0] move_distance;
  logic [prp_pkg::IDLE_W-1:0] idling_pulse_setting;
  prp_pkg::prp_state_t state;
  prp_pkg::prp_state_t next_state;
  logic [prp_pkg::MOVE_W-1:0] remain;
  logic [prp_pkg::MOVE_W-1:0] accel_pulses;
  logic [prp_pkg::IDLE_W-1:0] idle_left;
  logic [prp_pkg::SPD_W-1:0] speed;
  logic [prp_pkg::STEP_W-1:0] step_cnt;

  // apb decode
  wire wr = psel & penable & pready & pwrite;
  wire hit_div = (paddr == prp_pkg::OFS_DIVIDER);
  wire hit_rdp = (paddr == prp_pkg::OFS_RDP);
  wire hit_aspan = (paddr == prp_pkg::OFS_ACC_SPAN);
  wire hit_dspan = (paddr == prp_pkg::OFS_DEC_SPAN);
  wire hit_mode = (paddr == prp_pkg::OFS_MODE);
  wire hit_low = (paddr == prp_pkg::OFS_LOW);
  wire hit_high = (paddr == prp_pkg::OFS_HIGH);
  wire hit_arate = (paddr == prp_pkg::OFS_ACC_RATE);
  wire hit_drate = (paddr == prp_pkg::OFS_DEC_RATE);
  wire hit_move = (paddr == prp_pkg::OFS_MOVE);
  wire hit_idle = (paddr == prp_pkg::OFS_IDLE);
  wire hit_cmd = (paddr == prp_pkg::OFS_CMD);
  wire hit_stat = (paddr == prp_pkg::OFS_STATUS);
  wire hit_rem = (paddr == prp_pkg::OFS_REMAIN);
  wire hit_spd = (paddr == prp_pkg::OFS_SPEED);
  wire hit_pt = (paddr == prp_pkg::OFS_POINT);
  wire mapped = hit_div | hit_rdp | hit_aspan | hit_dspan | hit_mode |
    hit_low | hit_high | hit_arate | hit_drate | hit_move | hit_idle |
    hit_cmd | hit_stat | hit_rem | hit_spd | hit_pt;
  wire start_cmd = wr & hit_cmd & pwdata[prp_pkg::CMD_START_BIT];
  wire stop_cmd = wr & hit_cmd & pwdata[prp_pkg::CMD_STOP_BIT];
  wire is_idle = (state == prp_pkg::ST_IDLE);
  // divider writes below the minimum are raised to it
  wire [prp_pkg::DIV_W-1:0] div_wdata = pwdata[prp_pkg::DIV_W-1:0];
  wire [prp_pkg::DIV_W-1:0] div_clamped =
    (div_wdata < prp_pkg::DIV_MIN) ? prp_pkg::DIV_MIN : div_wdata;

  // move magnitude and direction
  wire move_neg = move_distance[prp_pkg::MOVE_W-1];
  wire [prp_pkg::MOVE_W-1:0] move_abs =
    move_neg ? (~move_distance + 1'b1) : move_distance;
  // idling pulses: setting minus one when setting is 2 or more
  wire idle_on = (idling_pulse_setting >= prp_pkg::IDLE_MIN);
  wire [prp_pkg::IDLE_W-1:0] idle_count =
    idle_on ? (idling_pulse_setting - 1'b1) : '0;

  // effective s-curve spans
  wire [prp_pkg::SPD_W-1:0] half_diff =
    (high_speed_setting > low_speed_setting) ?
    ((high_speed_setting - low_speed_setting) >> 1) : '0;
  wire [prp_pkg::SPD_W-1:0] acc_span = (s_curve_accel_span == '0) ?
    half_diff : {1'b0, s_curve_accel_span};
  wire [prp_pkg::SPD_W-1:0] dec_span = (s_curve_decel_span == '0) ?
    half_diff : {1'b0, s_curve_decel_span};
  wire [prp_pkg::SPD_W-1:0] span =
    (state == prp_pkg::ST_DECEL) ? dec_span : acc_span;
  wire [prp_pkg::SPD_W:0] low_edge = {1'b0, low_speed_setting} + {1'b0, span};
  wire [prp_pkg::SPD_W:0] high_edge =
    {1'b0, high_speed_setting} - {1'b0, span};
  wire in_s_zone = ramp_shape_select &
    (({1'b0, speed} < low_edge) || ({1'b0, speed} >= high_edge));

  // ramp step period: (rate+1) times 4 linear, times 8 in s-curve zone
  wire [prp_pkg::SPD_W-1:0] eff_decel = (decel_rate_setting == '0) ?
    accel_rate_setting : decel_rate_setting;
  wire [prp_pkg::SPD_W-1:0] cur_rate =
    (state == prp_pkg::ST_DECEL) ? eff_decel : accel_rate_setting;
  wire [prp_pkg::STEP_W-1:0] mult = in_s_zone ?
    prp_pkg::STEP_S : prp_pkg::STEP_LIN;
  wire [prp_pkg::STEP_W-1:0] rate_plus =
    {{(prp_pkg::STEP_W-prp_pkg::SPD_W){1'b0}}, cur_rate} + 1'b1;
  wire [prp_pkg::STEP_W-1:0] step_limit =
    (prp_pkg::STEP_W)'(rate_plus * mult);
  wire step_due = (step_cnt + 1'b1 >= step_limit);
  wire ramping = (state == prp_pkg::ST_ACCEL) | (state == prp_pkg::ST_DECEL);

  // ramping-down point: manual threshold or offset on computed point
  wire signed [prp_pkg::MOVE_W:0] offset =
    (prp_pkg::MOVE_W+1)'($signed(ramp_down_point));
  wire signed [prp_pkg::MOVE_W:0] auto_sum =
    $signed({1'b0, accel_pulses}) + offset;
  wire [prp_pkg::MOVE_W-1:0] auto_point =
    auto_sum[prp_pkg::MOVE_W] ? '0 : auto_sum[prp_pkg::MOVE_W-1:0];
  wire [prp_pkg::MOVE_W-1:0] ramp_point = ramp_point_method ?
    {{(prp_pkg::MOVE_W-prp_pkg::RDP_W){1'b0}}, ramp_down_point} :
    auto_point;
  wire decel_hit = (remain <= ramp_point);
  wire last_pulse = pg.fire & (remain == {{(prp_pkg::MOVE_W-1){1'b0}}, 1'b1});
  wire reach_high = (speed >= high_speed_setting);
  wire reach_low = (speed <= low_speed_setting);

  // next state
  always_comb
  begin
    next_state = state;
    case (state)
      prp_pkg::ST_IDLE:
        if (start_cmd && move_abs != '0)
          next_state = idle_on ? prp_pkg::ST_IDLING : prp_pkg::ST_ACCEL;
      prp_pkg::ST_IDLING:
        if (pg.fire && idle_left == {{(prp_pkg::IDLE_W-1){1'b0}}, 1'b1})
          next_state = prp_pkg::ST_ACCEL;
      prp_pkg::ST_ACCEL:
        if (decel_hit)
          next_state = prp_pkg::ST_DECEL;
        else if (reach_high)
          next_state = prp_pkg::ST_CONST;
      prp_pkg::ST_CONST:
        if (decel_hit)
          next_state = prp_pkg::ST_DECEL;
      prp_pkg::ST_DECEL:
        if (reach_low)
          next_state = prp_pkg::ST_LOWFEED;
      prp_pkg::ST_LOWFEED:
        next_state = prp_pkg::ST_LOWFEED;
      default:
        next_state = prp_pkg::ST_IDLE;
    endcase
    if (stop_cmd || last_pulse || (!is_idle && remain == '0))
      next_state = prp_pkg::ST_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= prp_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // remaining count, idling count, pulses spent on idling and acceleration
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remain <= '0;
      accel_pulses <= '0;
      idle_left <= '0;
    end
    else if (is_idle && start_cmd)
    begin
      remain <= move_abs;
      accel_pulses <= '0;
      idle_left <= idle_count;
    end
    else if (!is_idle && pg.fire)
    begin
      remain <= remain - 1'b1;
      if (state == prp_pkg::ST_IDLING || state == prp_pkg::ST_ACCEL)
        accel_pulses <= accel_pulses + 1'b1;
      if (state == prp_pkg::ST_IDLING)
        idle_left <= idle_left - 1'b1;
    end
  end

  // speed ramp
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speed <= '0;
      step_cnt <= '0;
    end
    else if (is_idle)
    begin
      speed <= low_speed_setting;
      step_cnt <= '0;
    end
    else if (ramping)
    begin
      step_cnt <= step_due ? '0 : step_cnt + 1'b1;
      if (step_due && state == prp_pkg::ST_ACCEL && !reach_high)
        speed <= speed + 1'b1;
      if (step_due && state == prp_pkg::ST_DECEL && !reach_low)
        speed <= speed - 1'b1;
    end
    else
      step_cnt <= '0;
  end

  // pins
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_out <= 1'b0;
      dir_out <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      pulse_out <= pg.fire & !is_idle;
      if (is_idle && start_cmd)
        dir_out <= move_neg;
      busy <= (next_state != prp_pkg::ST_IDLE);
    end
  end
  assign pg.speed = speed;
  assign pg.divider = speed_unit_divider;
  assign pg.run = !is_idle;

  prp_pulse_gen u_gen (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pg(pg)
  );
  // register writes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speed_unit_divider <= prp_pkg::DIV_RST;
      ramp_down_point <= '0;
      s_curve_accel_span <= '0;
      s_curve_decel_span <= '0;
      ramp_point_method <= 1'b0;
      ramp_shape_select <= 1'b0;
      low_speed_setting <= prp_pkg::LOW_RST;
      high_speed_setting <= prp_pkg::HIGH_RST;
      accel_rate_setting <= prp_pkg::RATE_RST;
      decel_rate_setting <= '0;
      move_distance <= '0;
      idling_pulse_setting <= '0;
    end
    else if (wr)
    begin
      if (hit_div)
        speed_unit_divider <= div_clamped;
      if (hit_rdp)
        ramp_down_point <= pwdata[prp_pkg::RDP_W-1:0];
      if (hit_aspan)
        s_curve_accel_span <= pwdata[prp_pkg::SPAN_W-1:0];
      if (hit_dspan)
        s_curve_decel_span <= pwdata[prp_pkg::SPAN_W-1:0];
      if (hit_mode)
      begin
        ramp_point_method <= pwdata[prp_pkg::MODE_METHOD_BIT];
        ramp_shape_select <= pwdata[prp_pkg::MODE_SHAPE_BIT];
      end
      if (hit_low)
        low_speed_setting <= pwdata[prp_pkg::SPD_W-1:0];
      if (hit_high)
        high_speed_setting <= pwdata[prp_pkg::SPD_W-1:0];
      if (hit_arate)
        accel_rate_setting <= pwdata[prp_pkg::SPD_W-1:0];
      if (hit_drate)
        decel_rate_setting <= pwdata[prp_pkg::SPD_W-1:0];
      if (hit_move)
        move_distance <= pwdata;
      if (hit_idle)
        idling_pulse_setting <= pwdata[prp_pkg::IDLE_W-1:0];
    end
  end

  // read mux
  wire [31:0] rd_mux =
    hit_div ? {20'h00000, speed_unit_divider} :
    hit_rdp ? {8'h00, ramp_down_point} :
    hit_aspan ? {17'h0, s_curve_accel_span} :
    hit_dspan ? {17'h0, s_curve_decel_span} :
    hit_mode ? {30'h0, ramp_shape_select, ramp_point_method} :
    hit_low ? {16'h0000, low_speed_setting} :
    hit_high ? {16'h0000, high_speed_setting} :
    hit_arate ? {16'h0000, accel_rate_setting} :
    hit_drate ? {16'h0000, decel_rate_setting} :
    hit_move ? move_distance :
    hit_idle ? {29'h0, idling_pulse_setting} :
    hit_stat ? {23'h0, dir_out, 2'h0, state} :
    hit_rem ? remain :
    hit_spd ? {16'h0000, speed} :
    hit_pt ? ramp_point :
    32'h00000000;

  // apb: one wait state, answer registered
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_mux;
    end
  end
endmodule : prp_profile

// ==== prp_pkg.sv ====
package prp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DIVIDER = 8'h00;
  localparam logic [7:0] OFS_RDP = 8'h04;
  localparam logic [7:0] OFS_ACC_SPAN = 8'h08;
  localparam logic [7:0] OFS_DEC_SPAN = 8'h0C;
  localparam logic [7:0] OFS_MODE = 8'h10;
  localparam logic [7:0] OFS_LOW = 8'h14;
  localparam logic [7:0] OFS_HIGH = 8'h18;
  localparam logic [7:0] OFS_ACC_RATE = 8'h1C;
  localparam logic [7:0] OFS_DEC_RATE = 8'h20;
  localparam logic [7:0] OFS_MOVE = 8'h24;
  localparam logic [7:0] OFS_IDLE = 8'h28;
  localparam logic [7:0] OFS_CMD = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_REMAIN = 8'h34;
  localparam logic [7:0] OFS_SPEED = 8'h38;
  localparam logic [7:0] OFS_POINT = 8'h3C;
  // field positions
  localparam int MODE_METHOD_BIT = 0;
  localparam int MODE_SHAPE_BIT = 1;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int STAT_DIR_BIT = 8;
  // widths
  localparam int DIV_W = 12;
  localparam int RDP_W = 24;
  localparam int SPAN_W = 15;
  localparam int SPD_W = 16;
  localparam int MOVE_W = 32;
  localparam int IDLE_W = 3;
  localparam int STEP_W = 20;
  // reset values and limits
  localparam logic [DIV_W-1:0] DIV_MIN = 12'h002;
  localparam logic [DIV_W-1:0] DIV_RST = 12'h12B;
  localparam logic [SPD_W-1:0] LOW_RST = 16'h0001;
  localparam logic [SPD_W-1:0] HIGH_RST = 16'h0001;
  localparam logic [SPD_W-1:0] RATE_RST = 16'h0001;
  localparam logic [IDLE_W-1:0] IDLE_MIN = 3'h2;
  // ramp step period multipliers: linear and s-curve zones
  localparam logic [STEP_W-1:0] STEP_LIN = 20'h00004;
  localparam logic [STEP_W-1:0] STEP_S = 20'h00008;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_IDLING = 6'b000010,
    ST_ACCEL = 6'b000100,
    ST_CONST = 6'b001000,
    ST_DECEL = 6'b010000,
    ST_LOWFEED = 6'b100000
  } prp_state_t;
endpackage : prp_pkg

// ==== prp_pulse_if.sv ====
interface prp_pulse_if;
  logic [prp_pkg::SPD_W-1:0] speed;
  logic [prp_pkg::DIV_W-1:0] divider;
  logic run;
  logic fire;
  modport gen (input speed, input divider, input run, output fire);
  modport ctl (output speed, output divider, output run, input fire);
endinterface : prp_pulse_if

// ==== prp_pulse_gen.sv ====
module prp_pulse_gen (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  prp_pulse_if.gen pg // speed in, fire out
);
  logic [prp_pkg::DIV_W-1:0] pre_cnt;
  logic [prp_pkg::SPD_W-1:0] phase;
  logic fire;
  wire pre_wrap = (pre_cnt >= pg.divider);
  wire [prp_pkg::SPD_W:0] phase_sum = {1'b0, phase} + {1'b0, pg.speed};

  assign pg.fire = fire;

  // prescale by divider+1, then 16-bit phase add of the speed setting
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt <= '0;
      phase <= '0;
      fire <= 1'b0;
    end
    else if (!pg.run)
    begin
      pre_cnt <= '0;
      phase <= '0;
      fire <= 1'b0;
    end
    else
    begin
      pre_cnt <= pre_wrap ? '0 : pre_cnt + 1'b1;
      if (pre_wrap)
        phase <= phase_sum[prp_pkg::SPD_W-1:0];
      fire <= pre_wrap & phase_sum[prp_pkg::SPD_W];
    end
  end
endmodule : prp_pulse_gen

// ==== prp_profile_sva.sv ====
module prp_profile_sva (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic pulse_out, // step pulse
  input wire logic dir_out, // direction level
  input wire logic busy // move running
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic start_wr;
  assign start_wr = psel && penable && pready && pwrite &&
    paddr == prp_pkg::OFS_CMD && pwdata[prp_pkg::CMD_START_BIT];
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  ready_wait_a: assert property
    (psel && penable && !$past(penable) |=> pready)
    else $error("pready late after access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_decode_a: assert property (pready && paddr[1:0] == 2'b00 |->
    pslverr == (paddr > prp_pkg::OFS_POINT))
    else $error("pslverr does not match address map");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  start_busy_a: assert property
    ($rose(busy) |-> $past(start_wr) || $past(start_wr, 2))
    else $error("busy rose without start command");
  pulse_short_a: assert property (pulse_out |=> !pulse_out)
    else $error("step pulse longer than one cycle");
  pulse_busy_a: assert property (pulse_out |-> busy || $past(busy))
    else $error("step pulse outside a move");
  dir_hold_a: assert property (busy && $past(busy) |-> $stable(dir_out))
    else $error("direction changed during a move");
  cover property (start_wr);
  cover property ($fell(busy));
  cover property (pslverr);
  cover property (pulse_out && dir_out);
endmodule : prp_profile_sva

bind prp_profile prp_profile_sva prp_profile_sva_inst (.sys_clk(sys_clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pulse_out(pulse_out), .dir_out(dir_out), .busy(busy));

// ==== prp_driver_model.sv ====
module prp_driver_model (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic step, // step pulse from controller
  input wire logic dir, // direction level
  input wire logic clr, // clear counters
  output int steps, // steps since clear
  output int gap, // cycles between last two steps
  output logic last_dir // direction at last step
);
  timeunit 1ns;
  timeprecision 1ps;
  int since;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n || clr)
    begin
      steps <= 0;
      gap <= 0;
      since <= 0;
      last_dir <= 1'b0;
    end
    else if (step)
    begin
      steps <= steps + 1;
      gap <= since + 1;
      since <= 0;
      last_dir <= dir;
    end
    else
      since <= since + 1;
  end
endmodule : prp_driver_model

// ==== prp_profile_bench.sv ====
module prp_profile_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, psel, penable, pwrite, clr, e;
  logic pready, pslverr, pulse_out, dir_out, busy, last_dir;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int error_cnt, n_checks, cyc, t0, steps, gap;
  prp_profile prp_profile_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_out(pulse_out), .dir_out(dir_out), .busy(busy));
  prp_driver_model prp_driver_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .step(pulse_out), .dir(dir_out), .clr(clr), .steps(steps), .gap(gap),
    .last_dir(last_dir));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one apb transfer, result left in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("apb_answer", 32'(n < 50), 32'h1);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // read state until bit b of status equals v
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      rd(prp_pkg::OFS_STATUS);
      n++;
    end
    while (q[b] !== v && n < 5000);
    check("state_wait", 32'(n < 5000), 32'h1);
  endtask : poll
  task automatic run(input logic [31:0] mode, low, high, rdp, idle, mv);
    wr(prp_pkg::OFS_DIVIDER, 32'h2);
    wr(prp_pkg::OFS_ACC_SPAN, 32'h0);
    wr(prp_pkg::OFS_DEC_SPAN, 32'h0);
    wr(prp_pkg::OFS_MODE, mode);
    wr(prp_pkg::OFS_LOW, low);
    wr(prp_pkg::OFS_HIGH, high);
    wr(prp_pkg::OFS_RDP, rdp);
    wr(prp_pkg::OFS_IDLE, idle);
    wr(prp_pkg::OFS_MOVE, mv);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    wr(prp_pkg::OFS_CMD, 32'h1);
    t0 = cyc;
  endtask : run
  task automatic t_reset;
    // div rdp span span mode low high arate drate move idle
    logic [31:0] x [11] = '{12'h12B, 0, 0, 0, 0, 1, 1, 1, 0, 0, 0};
    for (int i = 0; i < 11; i++)
    begin
      rd(8'(i * 4));
      check("reset_value", q, x[i]);
    end
    rd(prp_pkg::OFS_STATUS);
    check("reset_state", q, 32'h1);
  endtask : t_reset
  task automatic t_limits;
    logic [7:0] a [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h0C, 8'h04};
    logic [31:0] d [7] = '{0, 1, 32'hFFF, 32'h1FFF, 32'hFFFF, 32'h7FFF, '1};
    logic [31:0] x [7] = '{2, 2, 32'hFFF, 32'hFFF, 32'h7FFF, 32'h7FFF,
      32'hFFFFFF};
    for (int i = 0; i < 7; i++)
    begin
      wr(a[i], d[i]);
      rd(a[i]);
      check("field_limit", q, x[i]);
    end
  endtask : t_limits
  task automatic t_refuse;
    wr(8'h40, 32'hFFFFFFFF);
    check("wr_refused", e, 1);
    rd(8'h40);
    check("rd_refused", e, 1);
    check("rd_refused_data", q, 0);
    rd(prp_pkg::OFS_CMD);
    check("cmd_reads_zero", q, 0);
  endtask : t_refuse
  task automatic t_rate;
    run(0, 32'h200, 32'h200, 0, 0, 8);
    poll(0, 1'b1);
    check("step_count", steps, 8);
    check("step_gap", gap, 3 * 65536 / 512);
    rd(prp_pkg::OFS_REMAIN);
    check("remain_end", q, 0);
    check("busy_end", busy, 0);
    check("pos_dir", last_dir, 0);
  endtask : t_rate
  task automatic t_stop;
    int s;
    run(0, 32'h200, 32'h200, 0, 0, 100);
    poll(3, 1'b1);
    wr(prp_pkg::OFS_CMD, 32'h2);
    repeat (2) @(posedge sys_clk);
    check("stop_busy", busy, 0);
    s = steps;
    rd(prp_pkg::OFS_STATUS);
    check("stop_state", q, 32'h1);
    repeat (400) @(posedge sys_clk);
    check("stop_steps", steps, s);
  endtask : t_stop
  task automatic t_idle;
    run(0, 32'h200, 32'h200, 0, 7, -32'sd12);
    poll(1, 1'b0);
    repeat (2) @(posedge sys_clk);
    check("idle_steps", steps, 6);
    poll(0, 1'b1);
    check("neg_steps", steps, 12);
    check("neg_dir", last_dir, 1);
  endtask : t_idle
  task automatic t_manual;
    int n;
    run(32'h3, 32'h200, 32'h300, 20, 0, 40);
    poll(2, 1'b0);
    n = cyc - t0;
    check("s_accel_time", 32'(n > 4085 && n < 4115), 1);
    poll(4, 1'b1);
    t0 = cyc;
    rd(prp_pkg::OFS_REMAIN);
    check("manual_decel", q, 20);
    rd(prp_pkg::OFS_POINT);
    check("manual_point", q, 20);
    poll(5, 1'b1);
    n = cyc - t0;
    check("s_decel_time", 32'(n > 4085 && n < 4115), 1);
    rd(prp_pkg::OFS_SPEED);
    check("low_feed", q, 32'h200);
    poll(0, 1'b1);
  endtask : t_manual
  task automatic t_auto(input int off);
    int n;
    run(0, 32'h200, 32'h300, 32'(off) & 32'hFFFFFF, 0, 30);
    poll(2, 1'b0);
    repeat (2) @(posedge sys_clk);
    n = steps + off;
    poll(4, 1'b1);
    rd(prp_pkg::OFS_POINT);
    check("auto_point", q, n);
    rd(prp_pkg::OFS_REMAIN);
    check("auto_decel", q, n);
    poll(0, 1'b1);
  endtask : t_auto
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clr = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_limits();
    t_refuse();
    t_rate();
    t_stop();
    t_idle();
    t_manual();
    t_auto(3);
    t_auto(-2);
    stop_test();
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    stop_test();
  end
endmodule : prp_profile_bench
